// >>> verilog/tmg_pkg.sv
// tmg_pkg: constants and types shared by the timed material gating logic.
// assumes a single 125 MHz clock; all times are turned into cycle counts here.
package tmg_pkg;
	localparam int unsigned BEAM_COUNT    = 40;
	localparam int unsigned RUN_W         = 6;
	localparam int unsigned GROUP_BEAMS   = 10;
	localparam int unsigned OFF_RUN       = 11;
	localparam int unsigned CLK_KHZ       = 125_000;
	localparam int unsigned WIN_MS        = 4000;
	localparam int unsigned PRE_MS        = 3700;
	localparam int unsigned AUTO_END_MS   = 1000;
	localparam int unsigned CTRL_END_MS   = 100;
	localparam int unsigned WIN_CYC       = WIN_MS * CLK_KHZ;
	localparam int unsigned PRE_CYC       = PRE_MS * CLK_KHZ;
	localparam int unsigned AUTO_END_CYC  = AUTO_END_MS * CLK_KHZ;
	localparam int unsigned CTRL_END_CYC  = CTRL_END_MS * CLK_KHZ;
	localparam int unsigned CNT_W         = 32;
	localparam logic [2:0]  MODE_RESET    = 3'h0;
	localparam logic [6:0]  SEG_BLANK     = 7'h00;
	localparam logic [6:0]  SEG_FAULT     = 7'h79;
	localparam logic [6:0]  SEG_DIGIT [1:6] = '{7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d};

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ARMED  = 2'b01,
		ST_BRIDGE = 2'b10
	} tmg_state_e;
endpackage

// >>> verilog/tmg_field_if.sv
// tmg_field_if: beam states in, field condition out, between gate and evaluator.
// assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
interface tmg_field_if;
	import tmg_pkg::*;
	logic [BEAM_COUNT-1:0] beams_blocked;
	logic                  reduced_res;
	logic                  field_violation_event;
	logic                  small_interrupt;
	logic                  field_clear;
	modport eval (
		input  beams_blocked,
		input  reduced_res,
		output field_violation_event,
		output small_interrupt,
		output field_clear
	);
	modport ctrl (
		output beams_blocked,
		output reduced_res,
		input  field_violation_event,
		input  small_interrupt,
		input  field_clear
	);
endinterface
`default_nettype wire

// >>> verilog/tmg_beam_eval.sv
// tmg_beam_eval: finds the longest run of adjacent interrupted beams.
// assumes beam bits are ordered by physical position; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module tmg_beam_eval
	import tmg_pkg::*;
(
	tmg_field_if.eval f
);
	logic [RUN_W-1:0] run;
	logic [RUN_W-1:0] max_run;

	always_comb begin
		run = '0;
		max_run = '0;
		for (int i = 0; i < BEAM_COUNT; i++) begin
			if (f.beams_blocked[i]) begin
				run = run + 1'b1;
			end else begin
				run = '0;
			end
			if (run > max_run) begin
				max_run = run;
			end
		end
	end

	assign f.field_violation_event = f.reduced_res ? (max_run >= RUN_W'(OFF_RUN))
	                                               : (max_run != '0);
	assign f.small_interrupt = (max_run != '0) && !f.field_violation_event;
	assign f.field_clear     = (max_run == '0);
endmodule
`default_nettype wire

// >>> verilog/tmg_gate.sv
// tmg_gate: gating sequence, mode decode and safety output of the receiver.
// assumes request and beam inputs are synchronous to i_ref_clk and debounced upstream.
//
// Summary of operation
// - reduced modes group ten beams; eleven adjacent interrupted beams switch outputs off
// - reduced resolution stays in force before, during and after gating
// - reduced resolution only in modes one and four; others use full resolution
// - field violation must follow the request within 4 s to bridge
// - gating ends automatically when field stays clear over one second
// - gating ends when field and request both inactive over 0.1 s
// - mode comes only from the cable wire bridge, no other configuration
// - selected mode number shown statically on seven segment display
// - channel 2 in modes one to three, channel 1 in four to six
// - bridging needs the request and a material field violation, or in modes one and four a small interrupt under 3.7 s old
`timescale 1ns/1ns
`default_nettype none
module tmg_gate
	import tmg_pkg::*;
#(
	parameter int unsigned P_WIN_CYC      = WIN_CYC,
	parameter int unsigned P_PRE_CYC      = PRE_CYC,
	parameter int unsigned P_AUTO_END_CYC = AUTO_END_CYC,
	parameter int unsigned P_CTRL_END_CYC = CTRL_END_CYC
) (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rst_n,
	input  wire logic [2:0]            i_mode_bridge,
	input  wire logic                  i_gating_request,
	input  wire logic [BEAM_COUNT-1:0] i_beams_blocked,
	output logic                       o_safety_switching_output,
	output logic                       o_bridging,
	output logic                       o_reduced_res,
	output logic                       o_channel_two,
	output logic                       o_short_response,
	output logic                       o_mode_fault,
	output logic [6:0]                 o_segments
);
	tmg_field_if fld ();

	tmg_state_e       state_reg;
	tmg_state_e       state_next;
	logic [2:0]       mode_reg;
	logic             mode_taken_reg;
	logic             req_d_reg;
	logic [CNT_W-1:0] win_cnt_reg;
	logic [CNT_W-1:0] pre_cnt_reg;
	logic [CNT_W-1:0] clr_cnt_reg;
	logic [CNT_W-1:0] ctl_cnt_reg;
	logic             mode_valid;
	logic             reduced;
	logic             req_rise;
	logic             pre_live;
	logic             auto_end;
	logic             ctrl_end;

	tmg_beam_eval u_eval (
		.f (fld)
	);

	assign mode_valid = (mode_reg >= 3'h1) && (mode_reg <= 3'h6);
	assign reduced = (mode_reg == 3'h1) || (mode_reg == 3'h4);
	assign fld.reduced_res   = reduced;
	assign fld.beams_blocked = i_beams_blocked;
	assign req_rise = i_gating_request && !req_d_reg;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			mode_reg       <= MODE_RESET;
			mode_taken_reg <= 1'b0;
		end else if (!mode_taken_reg) begin
			mode_reg       <= i_mode_bridge;
			mode_taken_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			req_d_reg <= 1'b0;
		end else begin
			req_d_reg <= i_gating_request;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			pre_cnt_reg <= '0;
		end else if (state_reg == ST_IDLE && fld.small_interrupt) begin
			if (pre_cnt_reg < P_PRE_CYC) begin
				pre_cnt_reg <= pre_cnt_reg + 1'b1;
			end
		end else begin
			pre_cnt_reg <= '0;
		end
	end
	// counter saturates, so a small object standing in idle past the limit cannot open a bridge; leaving idle restarts its age
	assign pre_live = fld.small_interrupt && (pre_cnt_reg < P_PRE_CYC);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			win_cnt_reg <= '0;
		end else if (state_reg == ST_ARMED) begin
			win_cnt_reg <= win_cnt_reg + 1'b1;
		end else begin
			win_cnt_reg <= '0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			clr_cnt_reg <= '0;
		end else if (state_reg == ST_BRIDGE && fld.field_clear) begin
			clr_cnt_reg <= clr_cnt_reg + 1'b1;
		end else begin
			clr_cnt_reg <= '0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ctl_cnt_reg <= '0;
		end else if (state_reg == ST_BRIDGE && !fld.field_violation_event
		             && !i_gating_request) begin
			ctl_cnt_reg <= ctl_cnt_reg + 1'b1;
		end else begin
			ctl_cnt_reg <= '0;
		end
	end

	assign auto_end = (clr_cnt_reg >= P_AUTO_END_CYC);
	assign ctrl_end = (ctl_cnt_reg >= P_CTRL_END_CYC);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (mode_valid && req_rise && reduced && pre_live) begin
					state_next = ST_BRIDGE;
				end else if (mode_valid && req_rise) begin
					state_next = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (!i_gating_request) begin
					state_next = ST_IDLE;
				// window closed first: a violation at the full window is already late
				end else if (win_cnt_reg >= P_WIN_CYC - 1) begin
					state_next = ST_IDLE;
				end else if (fld.field_violation_event) begin
					state_next = ST_BRIDGE;
				end
			end
			ST_BRIDGE: begin
				if (auto_end || ctrl_end) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_safety_switching_output <= 1'b0;
			o_bridging                <= 1'b0;
		end else begin
			// fail safe: an unknown strap keeps the outputs off
			o_safety_switching_output <= mode_valid && (state_next == ST_BRIDGE
			                             || !fld.field_violation_event);
			o_bridging                <= (state_next == ST_BRIDGE);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_reduced_res    <= 1'b0;
			o_channel_two    <= 1'b0;
			o_short_response <= 1'b0;
			o_mode_fault     <= 1'b0;
			o_segments       <= SEG_BLANK;
		end else begin
			o_reduced_res    <= reduced;
			o_channel_two    <= (mode_reg >= 3'h1) && (mode_reg <= 3'h3);
			o_short_response <= (mode_reg == 3'h3) || (mode_reg == 3'h6);
			o_mode_fault     <= mode_taken_reg && !mode_valid;
			if (!mode_taken_reg) begin
				o_segments <= SEG_BLANK;
			end else if (mode_valid) begin
				o_segments <= SEG_DIGIT[mode_reg];
			end else begin
				o_segments <= SEG_FAULT;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/tmg_gate_monitor.sv
// tmg_gate_monitor: port timing relations of the gate.
// assumes it is bound onto every tmg_gate instance.
`timescale 1ns/1ns
`default_nettype none
module tmg_gate_monitor
	import tmg_pkg::*;
(
	input wire logic                  i_ref_clk,
	input wire logic                  i_rst_n,
	input wire logic [2:0]            i_mode_bridge,
	input wire logic                  i_gating_request,
	input wire logic [BEAM_COUNT-1:0] i_beams_blocked,
	input wire logic                  o_safety_switching_output,
	input wire logic                  o_bridging,
	input wire logic                  o_reduced_res,
	input wire logic                  o_channel_two,
	input wire logic                  o_short_response,
	input wire logic                  o_mode_fault,
	input wire logic [6:0]            o_segments
);
	logic [1:0] up_reg;
	wire        settled = up_reg == 2'h2;
	wire        end_ok = i_beams_blocked == '0 || !i_gating_request;
	// mode outputs are only valid two edges after release
	always_ff @(posedge i_ref_clk) begin
		up_reg <= !i_rst_n ? 2'h0 : (settled ? up_reg : up_reg + 2'h1);
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	mode_hold_a: assert property ($past(settled) |-> $stable(o_reduced_res) &&
		$stable(o_channel_two) && $stable(o_short_response) && $stable(o_segments)) else
		$error("mode outputs changed after capture");
	reduced_mode_a: assert property (o_reduced_res |-> !o_short_response && !o_mode_fault)
		else $error("reduced resolution in a wrong mode");
	seg_digit_a: assert property (o_reduced_res |->
		o_segments == (o_channel_two ? SEG_DIGIT[1] : SEG_DIGIT[4])) else $error("bad digit");
	fault_off_a: assert property (settled && o_mode_fault |-> o_segments == SEG_FAULT &&
		!o_safety_switching_output && !o_bridging) else $error("invalid mode not refused");
	bridge_cause_a: assert property ($rose(o_bridging) |-> $past(i_gating_request))
		else $error("bridging without request");
	end_cause_a: assert property ($fell(o_bridging) && $past(i_rst_n) |->
		$past(end_ok, 2) && $past(end_ok, 5)) else $error("gating ended too early");
	full_off_a: assert property (settled && !o_reduced_res && !o_bridging &&
		$past(i_beams_blocked) != '0 |-> !o_safety_switching_output) else $error("full res on");
	group_tol_a: assert property (settled && o_reduced_res &&
		($past(i_beams_blocked) & ~40'h00_0000_03ff) == '0 |-> o_safety_switching_output)
		else $error("ten beams switched off");
	group_off_a: assert property (settled && o_reduced_res && !o_bridging &&
		($past(i_beams_blocked) & 40'h00_0000_07ff) == 40'h00_0000_07ff |->
		!o_safety_switching_output) else $error("eleven beams kept on");
endmodule
bind tmg_gate tmg_gate_monitor MON (.i_ref_clk, .i_rst_n, .i_mode_bridge, .i_gating_request,
	.i_beams_blocked, .o_safety_switching_output, .o_bridging, .o_reduced_res,
	.o_channel_two, .o_short_response, .o_mode_fault, .o_segments);
`default_nettype wire

// >>> dv/tmg_ctrl_model.sv
// tmg_ctrl_model: machine control raising the gating request.
// assumes the bench commands it from its process sequence.
`timescale 1ns/1ns
`default_nettype none
module tmg_ctrl_model (
	input  wire logic i_ref_clk,
	input  wire logic i_cmd,
	output var logic  o_req
);
	initial o_req = 1'b0;
	always @(posedge i_ref_clk) o_req <= i_cmd;
endmodule
`default_nettype wire

// >>> dv/tmg_gate_tb_top.sv
// tmg_gate_tb_top: cycle model of the gating sequence, run in every mode.
// assumes the control model delays each request by one cycle.
`timescale 1ns/1ns
`default_nettype none
module tmg_gate_tb_top;
	import tmg_pkg::*;
	logic        clk = 0, rst_n = 0, cmd = 0, req, sf, br, rr, c2, sr, mf, rq_d, v, m_br, m_sf;
	logic [2:0]  mode = 0;
	logic [39:0] bm = '0;
	logic [6:0]  sg;
	int          errors = 0, checked = 0, cyc = 0, st, pc, np, wc, ac, cc, run, r;
	wire         red = mode == 1 || mode == 4;
	wire         mv = mode inside {[1:6]};
	initial forever #4 clk = ~clk;
	tmg_ctrl_model PM (.i_ref_clk(clk), .i_cmd(cmd), .o_req(req));
	tmg_gate #(.P_WIN_CYC(40), .P_PRE_CYC(37), .P_AUTO_END_CYC(10), .P_CTRL_END_CYC(5)) DUT (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_mode_bridge(mode), .i_gating_request(req),
		.i_beams_blocked(bm), .o_safety_switching_output(sf), .o_bridging(br),
		.o_reduced_res(rr), .o_channel_two(c2), .o_short_response(sr), .o_mode_fault(mf),
		.o_segments(sg));
	always @(posedge clk) begin
		run = 0;
		r = 0;
		for (int i = 0; i < 40; i++) begin
			r = bm[i] ? r + 1 : 0;
			run = r > run ? r : run;
		end
		v = red ? run > 10 : run > 0;
		// small-object age follows the state held before this edge
		np = rst_n && st == 0 && run > 0 && !v ? pc + 1 : 0;
		if (!rst_n) st = 0;
		else if (st == 0 && req && !rq_d && mv) st = red && run > 0 && !v && pc < 37 ? 2 : 1;
		else if (st == 1 && (!req || wc >= 40)) st = 0;
		else if (st == 1 && v) st = 2;
		else if (st == 2 && (ac >= 10 || cc >= 5)) st = 0;
		pc = np;
		wc = st == 1 ? wc + 1 : 0;
		ac = st == 2 && bm == 0 ? ac + 1 : 0;
		cc = st == 2 && !v && !req ? cc + 1 : 0;
		rq_d = rst_n && req;
		m_br = st == 2;
		m_sf = mv && (st == 2 || !v);
	end
	task automatic cmp_bit(input logic a, input logic e);
		checked++;
		if (a !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
		end
	endtask
	task automatic cmp_seg(input logic [6:0] a, input logic [6:0] e);
		checked++;
		if (a !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
		end
	endtask
	// waits settle past the edge so registered outputs have landed
	task automatic ck(input int n);
		repeat (n) @(posedge clk);
		#1;
		cmp_bit(br, m_br);
		cmp_bit(sf, m_sf);
	endtask
	// runs sit at either end of the field, the awkward boundary case
	task automatic blk(input int n);
		@(posedge clk);
		bm <= ((40'h1 << n) - 40'h1) << ($urandom_range(0, 1) ? 0 : 40 - n);
	endtask
	task automatic cs(input logic b);
		@(posedge clk);
		cmd <= b;
	endtask
	task automatic stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			stop_test;
		end
	end
	initial begin
		void'($urandom(32'h5265_71c0));
		for (int m = 0; m < 8; m++) begin
			@(posedge clk);
			rst_n <= 0;
			mode <= m[2:0];
			repeat (5) @(posedge clk);
			rst_n <= 1;
			ck(4);
			cmp_bit(rr, red);
			cmp_bit(c2, mode inside {[1:3]});
			cmp_bit(sr, mode == 3 || mode == 6);
			cmp_bit(mf, !mv);
			cmp_seg(sg, mv ? SEG_DIGIT[mode] : SEG_FAULT);
			blk(10);
			ck(4);
			blk(11);
			ck(4);
			blk(0);
			cs(1);
			blk(11);
			ck(5);
			blk(0);
			ck(5);
			ck(15);
			// violation lands exactly at the end of the window: refused
			cs(0);
			cs(1);
			ck(40);
			blk(11);
			ck(5);
			// violation one cycle inside the window still bridges
			blk(0);
			cs(0);
			cs(1);
			ck(39);
			blk(11);
			ck(5);
			blk(3);
			cs(0);
			ck(12);
			blk(0);
			ck(20);
			blk(3);
			ck(8);
			cs(1);
			ck(4);
			blk(0);
			cs(0);
			ck(20);
			blk(3);
			ck(60);
			cs(1);
			ck(50);
			blk(0);
			cs(0);
			ck(20);
			$display("mode %0d done", m);
		end
		stop_test;
	end
endmodule
`default_nettype wire
